// *** core/mpi_link.sv ***
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Enabled link uses feedback pin with pull-up, driven low only open-drain.
// - Current output driver goes high-impedance while the link is enabled.
// - Both test enables high enable the link; keep them low otherwise.
// - Pin entry keeps the link active while both pins stay high, no window.
// - Every bit is Manchester coded with a mid-bit transition, both directions.
// - Frame is 2 start bits, 8 data bits, 1 parity bit.
// - The byte goes most significant bit first.
// - Frames with even parity, bad start bits or framing errors are dropped.
// - Commands are 2 or 3 frames and begin with a programmer command byte.
// - Write: receive command and data, program, wait, send read-back byte.
// - Read 0x4Y answers one frame with memory byte at address Y.
// - 0x51..0x53 write free, offset, gain bytes and answer the read-back.
// - 0x60 reloads adjustment registers from memory and answers 0x00.
// - 0x61 answers 0x01 and leaves programming mode.
// - 0xD5 answers 0x05, enters programming mode, line released high.
// - Undefined commands answer 0xE1 or 0xE2 depending on the code.
// - Line is low-dominant open-drain; delays keep drivers from clashing.
// - After power-on, calibration bytes are copied into adjustment registers.
// - Sensor operation is suspended while programming mode is active.
// - Received bit periods from 85 to 115 us are accepted.
// - Answer frame starts 180 to 330 us after the command frame ends.
// - Write read-back starts 16 to 21 ms after the data frame.
module mpi_link
	import mpi_pkg::*;
#(
	parameter logic [1:0] START_BITS = START_BITS_DEF,
	parameter logic MAN_ONE_FALL = MAN_ONE_FALL_DEF,
	parameter int unsigned INIT_CYC = INIT_CYC_DEF,
	parameter int unsigned LOGIN_CYC = LOGIN_CYC_DEF,
	parameter int unsigned TX_HALF_CYC = TX_HALF_CYC_DEF,
	parameter int unsigned RX_SHORT_MIN = RX_SHORT_MIN_DEF,
	parameter int unsigned RX_SHORT_MAX = RX_SHORT_MAX_DEF,
	parameter int unsigned RX_LONG_MIN = RX_LONG_MIN_DEF,
	parameter int unsigned RX_LONG_MAX = RX_LONG_MAX_DEF,
	parameter int unsigned RESP_CYC = RESP_CYC_DEF,
	parameter int unsigned PRG_CYC = PRG_CYC_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Feedback pin, open drain
	input wire logic feedback_pin_i,
	output logic feedback_pin_o,
	output logic feedback_pin_oe,
	// Test enable pins
	input wire logic test_enable_a,
	input wire logic test_enable_b,
	// Analog side controls
	output logic prog_link_enabled,
	output logic line_pullup_en,
	output logic current_output_hiz,
	output logic analog_suspend,
	output logic [7:0] offset_trim_byte,
	output logic [7:0] gain_trim_byte
);

	localparam logic [CW-1:0] CNT_MAX = '1;
	localparam logic [CW-1:0] INIT_C = CW'(INIT_CYC);
	localparam logic [CW-1:0] POR_END = CW'(INIT_CYC + LOGIN_CYC);
	localparam logic [CW-1:0] HALF_C = CW'(TX_HALF_CYC - 1);
	localparam logic [CW-1:0] SMIN_C = CW'(RX_SHORT_MIN);
	localparam logic [CW-1:0] SMAX_C = CW'(RX_SHORT_MAX);
	localparam logic [CW-1:0] LMIN_C = CW'(RX_LONG_MIN);
	localparam logic [CW-1:0] LMAX_C = CW'(RX_LONG_MAX);
	localparam logic [CW-1:0] RESP_C = CW'(RESP_CYC);
	localparam logic [CW-1:0] PRG_C = CW'(PRG_CYC);
	localparam logic [3:0] NBITS = 4'(FRAME_BITS);

	typedef struct packed {
		logic [2:0] fb_s;
		logic [2:0] ta_s;
		logic [2:0] tb_s;
		logic line;
		logic ta;
		logic tb;
		logic [CW-1:0] por_cnt;
		logic logged_in;
		logic en;
		mpi_state_t st;
		logic reload;
		logic use_nvm;
		logic [7:0] cmd;
		logic [3:0] adr;
		logic [7:0] rsp;
		logic rx_act;
		logic rx_mid;
		logic rx_err;
		logic [CW-1:0] rx_cnt;
		logic [3:0] rx_n;
		logic [10:0] rx_sh;
		logic [CW-1:0] mid_cnt;
		logic [10:0] tx_sh;
		logic [3:0] tx_n;
		logic tx_half;
		logic [CW-1:0] tx_cnt;
		logic drv_low;
		logic nvm_we;
		logic [7:0] nvm_wd;
		logic [7:0] ofs;
		logic [7:0] gain;
		logic ctrl_block;
		logic wb_ack;
		logic [31:0] wb_dat;
	} mpi_link_st_t;

	localparam mpi_link_st_t RST_S = '{
		fb_s: {3{LINE_IDLE}},
		line: LINE_IDLE,
		st: ST_LOAD0,
		ctrl_block: CTRL_RST,
		default: '0
	};

	mpi_link_st_t s_q;
	mpi_link_st_t s_d;
	logic [3:0] nvm_addr;
	logic [7:0] nvm_rd;

	// Whole frame: start bits, byte MSB first, parity making the ones count odd
	function automatic logic [10:0] tx_frame(input logic [7:0] b);
		tx_frame = {START_BITS, b, ~(^{START_BITS, b})};
	endfunction

	// Level of one half bit; a bit equal to the polarity flag falls at mid-bit
	function automatic logic half_level(input logic b, input logic second);
		half_level = (b == MAN_ONE_FALL) ^ second;
	endfunction

	// Error answer chosen by the top bit of the unknown code
	function automatic logic [7:0] err_code(input logic [7:0] c);
		err_code = c[7] ? RSP_ERR_HI : RSP_ERR_LO;
	endfunction

	// Next-state logic for the whole block
	always_comb begin
		logic edge_v;
		logic fall_v;
		logic short_v;
		logic long_v;
		logic take_v;
		logic pin_entry;
		logic window;
		logic link_on;
		logic rx_en;
		logic frm_ok;
		logic [7:0] frm_byte;
		edge_v = 1'b0;
		fall_v = 1'b0;
		short_v = 1'b0;
		long_v = 1'b0;
		take_v = 1'b0;
		frm_ok = 1'b0;
		frm_byte = s_q.rx_sh[8:1];
		s_d = s_q;
		s_d.nvm_we = 1'b0;

		// Pin synchronisers; a change counts once stages two and three agree
		s_d.fb_s = {s_q.fb_s[1:0], feedback_pin_i};
		s_d.ta_s = {s_q.ta_s[1:0], test_enable_a};
		s_d.tb_s = {s_q.tb_s[1:0], test_enable_b};
		edge_v = (s_q.fb_s[1] == s_q.fb_s[2]) && (s_q.fb_s[2] != s_q.line);
		fall_v = edge_v && !s_q.fb_s[2];
		if (edge_v) begin
			s_d.line = s_q.fb_s[2];
		end
		if (s_q.ta_s[1] == s_q.ta_s[2]) begin
			s_d.ta = s_q.ta_s[2];
		end
		if (s_q.tb_s[1] == s_q.tb_s[2]) begin
			s_d.tb = s_q.tb_s[2];
		end

		// Entry paths: pins override any window, log-in window opens after init
		pin_entry = s_q.ta && s_q.tb;
		if (s_q.por_cnt != POR_END) begin
			s_d.por_cnt = s_q.por_cnt + 1'b1;
		end
		window = (s_q.por_cnt >= INIT_C) && (s_q.por_cnt < POR_END);
		link_on = pin_entry || s_q.logged_in || (window && !s_q.ctrl_block);
		s_d.en = link_on;
		if (s_q.mid_cnt != CNT_MAX) begin
			s_d.mid_cnt = s_q.mid_cnt + 1'b1;
		end

		// Receiver: classify edge spacing as half or whole bit, sample at mid-bit
		rx_en = link_on && (s_q.st == ST_IDLE || s_q.st == ST_WDATA);
		if (!rx_en) begin
			s_d.rx_act = 1'b0;
		end else if (!s_q.rx_act) begin
			if (fall_v) begin
				s_d.rx_act = 1'b1;
				s_d.rx_err = 1'b0;
				s_d.rx_cnt = '0;
				s_d.rx_sh = '0;
				s_d.rx_n = '0;
				s_d.rx_mid = (START_BITS[1] == MAN_ONE_FALL);
				if (START_BITS[1] == MAN_ONE_FALL) begin
					s_d.rx_sh = {10'h000, START_BITS[1]};
					s_d.rx_n = 4'h1;
					s_d.mid_cnt = '0;
				end
			end
		end else begin
			if (s_q.rx_cnt != CNT_MAX) begin
				s_d.rx_cnt = s_q.rx_cnt + 1'b1;
			end
			if (edge_v) begin
				s_d.rx_cnt = '0;
				short_v = (s_q.rx_cnt >= SMIN_C) && (s_q.rx_cnt <= SMAX_C);
				long_v = (s_q.rx_cnt >= LMIN_C) && (s_q.rx_cnt <= LMAX_C);
				if (s_q.rx_mid) begin
					if (short_v) begin
						s_d.rx_mid = 1'b0;
					end else if (long_v) begin
						take_v = 1'b1;
					end else begin
						s_d.rx_err = 1'b1;
					end
				end else if (short_v) begin
					s_d.rx_mid = 1'b1;
					take_v = 1'b1;
				end else begin
					s_d.rx_err = 1'b1;
				end
				if (take_v) begin
					if (s_q.rx_n == NBITS) begin
						s_d.rx_err = 1'b1;
					end else begin
						s_d.rx_sh = {s_q.rx_sh[9:0], fall_v ? MAN_ONE_FALL : !MAN_ONE_FALL};
						s_d.rx_n = s_q.rx_n + 1'b1;
						s_d.mid_cnt = '0;
					end
				end
			end else if (s_q.rx_cnt >= LMAX_C) begin
				// Silence ends the frame; only a clean one is passed on
				s_d.rx_act = 1'b0;
				frm_ok = !s_q.rx_err && (s_q.rx_n == NBITS) && (s_q.rx_sh[10:9] == START_BITS) &&
					(^s_q.rx_sh) && s_q.line;
			end
		end

		// Command sequencer
		case (s_q.st)
			ST_LOAD0: begin
				s_d.st = ST_LOAD1;
			end
			ST_LOAD1: begin
				s_d.ofs = nvm_rd;
				s_d.st = ST_LOAD2;
			end
			ST_LOAD2: begin
				s_d.gain = nvm_rd;
				if (s_q.reload) begin
					s_d.reload = 1'b0;
					s_d.use_nvm = 1'b0;
					s_d.rsp = RSP_RELOAD;
					s_d.st = ST_RESP;
				end else begin
					s_d.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// Only log-in is heard while the window alone keeps the link on
				if (frm_ok && (pin_entry || s_q.logged_in || frm_byte == CMD_LOGIN)) begin
					s_d.cmd = frm_byte;
					s_d.adr = frm_byte[3:0];
					s_d.use_nvm = 1'b0;
					s_d.st = ST_RESP;
					if (frm_byte[7:4] == CMD_READ_HI) begin
						s_d.use_nvm = 1'b1;
					end else if (frm_byte[7:4] == CMD_WRITE_HI && frm_byte[3:0] >= NVM_FREE1 &&
						frm_byte[3:0] <= NVM_GAIN) begin
						s_d.st = ST_WDATA;
					end else if (frm_byte == CMD_RELOAD) begin
						s_d.reload = 1'b1;
						s_d.st = ST_LOAD0;
					end else if (frm_byte == CMD_EXIT) begin
						s_d.rsp = RSP_EXIT;
					end else if (frm_byte == CMD_LOGIN) begin
						s_d.rsp = RSP_LOGIN;
					end else begin
						s_d.rsp = err_code(frm_byte);
					end
				end
			end
			ST_WDATA: begin
				if (frm_ok) begin
					s_d.nvm_we = 1'b1;
					s_d.nvm_wd = frm_byte;
					s_d.st = ST_PRG;
				end
			end
			ST_PRG: begin
				// Read-back waits out the programming time, counted from the last mid-bit
				if (s_q.mid_cnt >= PRG_C) begin
					s_d.tx_sh = tx_frame(nvm_rd);
					s_d.st = ST_TX;
				end
			end
			ST_RESP: begin
				if (s_q.mid_cnt >= RESP_C) begin
					s_d.tx_sh = tx_frame(s_q.use_nvm ? nvm_rd : s_q.rsp);
					s_d.st = ST_TX;
				end
			end
			ST_TX: begin
				if (s_q.tx_cnt == HALF_C) begin
					s_d.tx_cnt = '0;
					s_d.tx_half = !s_q.tx_half;
					if (s_q.tx_half) begin
						s_d.tx_sh = {s_q.tx_sh[9:0], 1'b0};
						s_d.tx_n = s_q.tx_n + 1'b1;
						if (s_q.tx_n == NBITS - 1'b1) begin
							s_d.st = ST_IDLE;
							if (s_q.cmd == CMD_EXIT) begin
								s_d.logged_in = 1'b0;
							end
							if (s_q.cmd == CMD_LOGIN) begin
								s_d.logged_in = 1'b1;
							end
						end
					end
				end else begin
					s_d.tx_cnt = s_q.tx_cnt + 1'b1;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		if (s_d.st != ST_TX) begin
			s_d.tx_cnt = '0;
			s_d.tx_n = '0;
			s_d.tx_half = 1'b0;
		end

		// Dropping the link abandons any pending command, except that a running load sequence finishes first
		if (!link_on && !(s_q.st inside {ST_LOAD0, ST_LOAD1, ST_LOAD2})) begin
			s_d.st = ST_IDLE;
			s_d.reload = 1'b0;
		end
		s_d.drv_low = (s_d.st == ST_TX) && !half_level(s_d.tx_sh[10], s_d.tx_half);

		// Wishbone slave: one wait state, unmapped reads give zero
		s_d.wb_ack = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
		if (s_d.wb_ack) begin
			s_d.wb_dat = '0;
			if (wb_we_i) begin
				if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
					s_d.ctrl_block = wb_dat_i[0];
				end
			end else begin
				case (wb_adr_i)
					REG_CTRL: s_d.wb_dat = {31'h0000_0000, s_q.ctrl_block};
					REG_STATUS: s_d.wb_dat = {16'h0000, s_q.cmd, 3'h0, s_q.st != ST_IDLE, window,
						pin_entry, s_q.logged_in, s_q.en};
					REG_ADJUST: s_d.wb_dat = {16'h0000, s_q.gain, s_q.ofs};
					default: s_d.wb_dat = '0;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= RST_S;
		end else begin
			s_q <= s_d;
		end
	end

	// Address steered by the load sequence, otherwise by the command
	assign nvm_addr = (s_q.st == ST_LOAD0) ? NVM_OFFSET : (s_q.st == ST_LOAD1) ? NVM_GAIN : s_q.adr;

	mpi_nvm #(
		.AW(NVM_AW),
		.DW(8)
	) u_nvm (
		.clk(clk),
		.rstn(rstn),
		.we(s_q.nvm_we),
		.addr(nvm_addr),
		.wdata(s_q.nvm_wd),
		.rdata(nvm_rd)
	);

	// Pin side never drives high; the pull-up makes the recessive level
	assign feedback_pin_o = 1'b0;
	assign feedback_pin_oe = s_q.drv_low;
	assign prog_link_enabled = s_q.en;
	assign line_pullup_en = s_q.en;
	assign current_output_hiz = s_q.en;
	assign analog_suspend = s_q.en;
	assign offset_trim_byte = s_q.ofs;
	assign gain_trim_byte = s_q.gain;
	assign wb_ack_o = s_q.wb_ack;
	assign wb_dat_o = s_q.wb_dat;

endmodule
`default_nettype wire

// *** core/mpi_nvm.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpi_nvm
	import mpi_pkg::*;
#(
	parameter int unsigned AW = NVM_AW,
	parameter int unsigned DW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Access port
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);

	typedef struct packed {
		logic [2**AW-1:0][DW-1:0] mem;
		logic [DW-1:0] rd;
	} mpi_nvm_st_t;

	mpi_nvm_st_t s_q;
	mpi_nvm_st_t s_d;

	// Read returns the stored word one cycle later, so a write shows up two cycles on
	always_comb begin
		s_d = s_q;
		s_d.rd = s_q.mem[addr];
		if (we) begin
			s_d.mem[addr] = wdata;
		end
	end

	// Cell array; the reset image stands in for cells that keep their charge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{mem: {(2**AW){NVM_RST}}, rd: NVM_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rd;

endmodule
`default_nettype wire

// *** pkg/mpi_pkg.sv ***
package mpi_pkg;

	// Clock and counter sizing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CW = 24;

	// Line timing in ns as specified
	localparam int unsigned BIT_TX_NS = 100000;
	localparam int unsigned RX_BIT_MIN_NS = 85000;
	localparam int unsigned RX_BIT_MAX_NS = 115000;
	localparam int unsigned RX_SHORT_MIN_NS = RX_BIT_MIN_NS * 45 / 100;
	localparam int unsigned RX_SHORT_MAX_NS = RX_BIT_MAX_NS * 55 / 100;
	localparam int unsigned TX_DLY_MIN_NS = 180000;
	localparam int unsigned TX_DLY_MAX_NS = 330000;
	localparam int unsigned PRG_DLY_MIN_NS = 16000000;
	localparam int unsigned PRG_DLY_MAX_NS = 21000000;
	localparam int unsigned INIT_NS = 1000000;
	localparam int unsigned LOGIN_NS = 20000000;

	// Derived cycle counts; least times round up, longest round down
	localparam int unsigned TX_HALF_CYC_DEF = BIT_TX_NS / 2 / CLK_PERIOD_NS;
	localparam int unsigned RX_SHORT_MIN_DEF = (RX_SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RX_SHORT_MAX_DEF = RX_SHORT_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned RX_LONG_MIN_DEF = (2 * RX_SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RX_LONG_MAX_DEF = 2 * RX_SHORT_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned RESP_CYC_DEF = (BIT_TX_NS / 2 + (TX_DLY_MIN_NS + TX_DLY_MAX_NS) / 2) / CLK_PERIOD_NS;
	localparam int unsigned PRG_CYC_DEF = ((PRG_DLY_MIN_NS + PRG_DLY_MAX_NS) / 2) / CLK_PERIOD_NS;
	localparam int unsigned INIT_CYC_DEF = INIT_NS / CLK_PERIOD_NS;
	localparam int unsigned LOGIN_CYC_DEF = LOGIN_NS / CLK_PERIOD_NS;

	// Frame format
	localparam int unsigned FRAME_BITS = 11;
	localparam logic [1:0] START_BITS_DEF = 2'h3;
	localparam logic MAN_ONE_FALL_DEF = 1'b1;
	localparam logic LINE_IDLE = 1'b1;

	// Commands and answers
	localparam logic [3:0] CMD_READ_HI = 4'h4;
	localparam logic [3:0] CMD_WRITE_HI = 4'h5;
	localparam logic [7:0] CMD_RELOAD = 8'h60;
	localparam logic [7:0] CMD_EXIT = 8'h61;
	localparam logic [7:0] CMD_LOGIN = 8'hD5;
	localparam logic [7:0] RSP_RELOAD = 8'h00;
	localparam logic [7:0] RSP_EXIT = 8'h01;
	localparam logic [7:0] RSP_LOGIN = 8'h05;
	localparam logic [7:0] RSP_ERR_LO = 8'hE1;
	localparam logic [7:0] RSP_ERR_HI = 8'hE2;

	// Non-volatile memory map
	localparam int unsigned NVM_AW = 4;
	localparam logic [3:0] NVM_FREE1 = 4'h1;
	localparam logic [3:0] NVM_OFFSET = 4'h2;
	localparam logic [3:0] NVM_GAIN = 4'h3;
	localparam logic [7:0] NVM_RST = 8'h00;

	// Register map (byte addresses)
	localparam int unsigned WB_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ADJUST = 8'h08;
	localparam logic CTRL_RST = 1'b0;

	// Controller states
	typedef enum logic [7:0] {
		ST_LOAD0 = 8'h01,
		ST_LOAD1 = 8'h02,
		ST_LOAD2 = 8'h04,
		ST_IDLE = 8'h08,
		ST_WDATA = 8'h10,
		ST_PRG = 8'h20,
		ST_RESP = 8'h40,
		ST_TX = 8'h80
	} mpi_state_t;

endpackage

// *** tb/mpi_link_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpi_link_asserts #(
	parameter int unsigned TX_HALF_CYC = 50
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Line and test pins
	input wire logic feedback_pin_i,
	input wire logic feedback_pin_o,
	input wire logic feedback_pin_oe,
	input wire logic test_enable_a,
	input wire logic test_enable_b,
	// Mode outputs
	input wire logic prog_link_enabled,
	input wire logic line_pullup_en,
	input wire logic current_output_hiz,
	input wire logic analog_suspend
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [15:0] run_q;
	logic [15:0] run_d;
	// Length of the current low drive, so half-bit timing can be judged at release
	always_comb run_d = feedback_pin_oe ? run_q + 16'h0001 : 16'h0000;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_q <= 16'h0000;
		end else begin
			run_q <= run_d;
		end
	end
	AST_OD_DRIVE: assert property (feedback_pin_oe |-> prog_link_enabled && !feedback_pin_o)
		else $error("Line pulled while link off");
	AST_PULLUP: assert property (line_pullup_en == prog_link_enabled)
		else $error("Pull-up not following link");
	AST_HIZ: assert property (current_output_hiz == prog_link_enabled)
		else $error("Output driver not high impedance");
	AST_SUSPEND: assert property (analog_suspend == prog_link_enabled)
		else $error("Sensor not suspended");
	AST_PIN_ENTRY: assert property ((test_enable_a && test_enable_b) [*6] |-> prog_link_enabled)
		else $error("Pins high but link off");
	AST_HALF_BIT: assert property ($fell(feedback_pin_oe) |-> run_q == TX_HALF_CYC || run_q == 2 * TX_HALF_CYC)
		else $error("Low drive not one or two half bits");
	AST_CLEAN_START: assert property ($rose(feedback_pin_oe) |-> $past(feedback_pin_i))
		else $error("Device pulled a line already low");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Ack longer than one cycle");
	AST_ACK_PROMPT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Ack late");
	// Main scenarios
	COV_ENTER: cover property ($rose(prog_link_enabled));
	COV_LEAVE: cover property ($fell(prog_link_enabled));
	COV_FULL_BIT: cover property ($fell(feedback_pin_oe) && run_q == 2 * TX_HALF_CYC);
endmodule
`default_nettype wire

// *** tb/mpi_prog_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpi_prog_host #(
	parameter int HALF = 50
) (
	// Clock
	input wire logic clk,
	// Shared line
	input wire logic line,
	output logic oe
);
	// Stretches or shrinks the sent half bit, so receive tolerance can be exercised
	int skew = 0;
	// Released at start; the model only ever pulls low
	initial oe = 1'b0;
	// One frame: two start ones, byte msb first, odd parity; bad breaks the parity
	task automatic send(input logic [7:0] b, input logic bad);
		logic [10:0] f;
		f = {2'b11, b, (~^b) ^ bad};
		for (int i = 10; i >= 0; i--) begin
			oe <= ~f[i];
			repeat (HALF + skew) @(posedge clk);
			oe <= f[i];
			repeat (HALF + skew) @(posedge clk);
		end
		oe <= 1'b0;
		// Let the release settle, else a listener would still see our own low level
		@(posedge clk);
	endtask
	// Waits up to lim cycles for a frame, then samples the middle of each second half
	task automatic recv(output logic [7:0] b, output int gap, output logic ok, input int lim);
		logic [10:0] f;
		gap = 0;
		f = 11'h000;
		while (line !== 1'b0 && gap < lim) begin
			@(posedge clk);
			gap++;
		end
		ok = (line === 1'b0);
		if (ok) begin
			repeat (HALF / 2) @(posedge clk);
			for (int i = 10; i >= 0; i--) begin
				f[i] = ~line;
				repeat (2 * HALF) @(posedge clk);
			end
		end
		b = f[8:1];
		ok = ok && f[10:9] == 2'b11 && (^f) === 1'b1;
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mpi_pkg::*;
	localparam int HALF = 50;
	localparam int PRG = 2000;
	localparam int INIT = 100;
	localparam int LOGIN = 5000;
	localparam int SMIN = 38;
	localparam int SMAX = 63;
	localparam int LMIN = 77;
	localparam int LMAX = 126;
	localparam int RESP = 305;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [3:0] sel = 4'hF;
	logic [31:0] rdat;
	logic ack;
	logic te_a = 1'b0;
	logic te_b = 1'b0;
	logic oe_dev;
	logic oe_host;
	logic line;
	logic en;
	logic hiz;
	logic susp;
	logic [7:0] offs;
	logic [7:0] gain;
	int failures = 0;
	int check_count = 0;
	// Open-drain line: any party pulling wins, pull-up otherwise
	assign line = (oe_dev | oe_host) ? 1'b0 : 1'b1;
	always #5 clk = ~clk;
	// Short counts keep the run brief; one cycle stands for one microsecond
	mpi_link #(.INIT_CYC(INIT), .LOGIN_CYC(LOGIN), .TX_HALF_CYC(HALF), .RX_SHORT_MIN(SMIN), .RX_SHORT_MAX(SMAX),
		.RX_LONG_MIN(LMIN), .RX_LONG_MAX(LMAX), .RESP_CYC(RESP), .PRG_CYC(PRG)) DUT (
		.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .feedback_pin_i(line),
		.feedback_pin_o(), .feedback_pin_oe(oe_dev), .test_enable_a(te_a), .test_enable_b(te_b),
		.prog_link_enabled(en), .line_pullup_en(), .current_output_hiz(hiz), .analog_suspend(susp),
		.offset_trim_byte(offs), .gain_trim_byte(gain));
	mpi_prog_host #(.HALF(HALF)) host (.clk(clk), .line(line), .oe(oe_host));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Classic single cycle; holds the request until ack is sampled, only the watchdog ends a lost ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Answer must start 180..330 after frame end, plus half a bit to its first fall
	task automatic xfer(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] b;
		logic ok;
		int gap;
		host.send(c, 1'b0);
		host.recv(b, gap, ok, 3000);
		chk({7'h00, ok}, 8'h01);
		chk(b, e);
		chk({7'h00, gap >= 230 && gap <= 380}, 8'h01);
	endtask
	// Data frame follows after more than the three-bit gap between frames
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] b;
		logic ok;
		int gap;
		host.send(c, 1'b0);
		repeat (400) @(posedge clk);
		host.send(d, 1'b0);
		host.recv(b, gap, ok, 5000);
		chk(b, d);
		chk({7'h00, ok && gap >= PRG - 2 * HALF && gap <= PRG + 2 * HALF}, 8'h01);
	endtask
	task automatic t_regs();
		logic [31:0] r;
		repeat (120) @(posedge clk);
		wb(1'b0, REG_ADJUST, 32'h00000000, r);
		chk(r[7:0], NVM_RST);
		chk(r[15:8], NVM_RST);
		wb(1'b1, 8'h40, 32'hFFFFFFFF, r);
		wb(1'b0, 8'h40, 32'h00000000, r);
		chk(r[7:0], 8'h00);
		wb(1'b0, REG_STATUS, 32'h00000000, r);
		chk({3'h0, r[4:0]}, 8'h09);
		// Control write without byte lane 0 must not land
		sel <= 4'hE;
		wb(1'b1, REG_CTRL, 32'h00000001, r);
		sel <= 4'hF;
		wb(1'b0, REG_CTRL, 32'h00000000, r);
		chk(r[7:0], 8'h00);
		// Blocking the window turns the link off while the window stays open
		wb(1'b1, REG_CTRL, 32'h00000001, r);
		wb(1'b0, REG_STATUS, 32'h00000000, r);
		chk({3'h0, r[4:0]}, 8'h08);
		wb(1'b1, REG_CTRL, 32'h00000000, r);
		$display("t_regs done");
	endtask
	task automatic t_login();
		logic [31:0] r;
		xfer(CMD_LOGIN, RSP_LOGIN);
		chk({5'h00, en, hiz, susp}, 8'h07);
		wb(1'b0, REG_STATUS, 32'h00000000, r);
		chk({7'h00, r[1]}, 8'h01);
		$display("t_login done");
	endtask
	task automatic t_write();
		wr(8'h51, 8'h3C);
		wr(8'h52, 8'hA5);
		wr(8'h53, 8'h96);
		chk(offs, 8'h00);
		xfer(CMD_RELOAD, RSP_RELOAD);
		chk(offs, 8'hA5);
		chk(gain, 8'h96);
		xfer(8'h41, 8'h3C);
		xfer(8'h43, 8'h96);
		xfer(8'h40, 8'h00);
		$display("t_write done");
	endtask
	task automatic t_errors();
		logic [7:0] b;
		logic ok;
		int gap;
		xfer(8'h70, RSP_ERR_LO);
		xfer(8'h80, RSP_ERR_HI);
		xfer(8'h54, RSP_ERR_LO);
		host.send(8'h40, 1'b1);
		host.recv(b, gap, ok, 600);
		chk({7'h00, ok}, 8'h00);
		xfer(8'h42, 8'hA5);
		// Bit periods near both ends of the accepted range
		host.skew = 6;
		xfer(8'h41, 8'h3C);
		host.skew = -6;
		xfer(8'h43, 8'h96);
		host.skew = 0;
		$display("t_errors done");
	endtask
	task automatic t_exit_pins();
		xfer(CMD_EXIT, RSP_EXIT);
		repeat (5) @(posedge clk);
		chk({6'h00, en, hiz}, 8'h00);
		te_a <= 1'b1;
		te_b <= 1'b1;
		repeat (110) @(posedge clk);
		chk({7'h00, en}, 8'h01);
		xfer(8'h43, 8'h96);
		te_b <= 1'b0;
		repeat (10) @(posedge clk);
		chk({7'h00, en}, 8'h00);
		$display("t_exit_pins done");
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence; reset doubles as the fast supply reset
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_login();
		t_write();
		t_errors();
		t_exit_pins();
		end_sim();
	end
	// Traffic needs about 55k cycles; 90k cycles ends a hang
	initial begin
		#900000;
		failures++;
		end_sim();
	end
endmodule
bind mpi_link mpi_link_asserts #(.TX_HALF_CYC(TX_HALF_CYC)) u_chk (
	.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.feedback_pin_i(feedback_pin_i), .feedback_pin_o(feedback_pin_o), .feedback_pin_oe(feedback_pin_oe),
	.test_enable_a(test_enable_a), .test_enable_b(test_enable_b), .prog_link_enabled(prog_link_enabled),
	.line_pullup_en(line_pullup_en), .current_output_hiz(current_output_hiz), .analog_suspend(analog_suspend));
`default_nettype wire
